/* File: laser_safety_map.svh */
`ifndef LASER_SAFETY_MAP_SVH
`define LASER_SAFETY_MAP_SVH

// ---------------------------------------------------------------
// widths and clock
// ---------------------------------------------------------------
`define SINK_W 8
`define CNT_W 24
`define CLK_KHZ 100000

// ---------------------------------------------------------------
// times as specified, in their own units
// ---------------------------------------------------------------
`define T_OFF_US 5
`define T_ON_NORMAL_US 800
`define T_INIT_DACS_MS 100
`define T_TRIP_US 50
`define T_INIT_SF_MS 50
`define T_FAULT_RESET_MIN_MS 100
`define T_FAULT_RESET_MAX_MS 200
`define T_SOFT_MS 50

// ---------------------------------------------------------------
// chosen wait before sinks ramp during initialisation
// ---------------------------------------------------------------
`define T_INIT_DAC_MS 40

// ---------------------------------------------------------------
// derived cycle counts (least times round up, ms * kHz is exact)
// ---------------------------------------------------------------
`define INIT_DAC_CYCLES (`T_INIT_DAC_MS * `CLK_KHZ)
`define FAULT_RESET_CYCLES (`T_FAULT_RESET_MIN_MS * `CLK_KHZ)

`endif

/* File: laser_safety_pkg.sv */
package laser_safety_pkg;

	typedef enum logic [1:0] {
		ST_INIT = 2'b00,
		ST_RUN = 2'b01,
		ST_DISABLED = 2'b10,
		ST_FAULT = 2'b11
	} mode_t;

	typedef struct packed {
		mode_t mode;
		logic [23:0] cnt;
		logic fault;
		logic ready;
		logic sink_en;
		logic oe;
		logic loss;
		logic rate;
		logic nv_pend;
		logic nv_start;
	} ctrl_state_t;

	typedef struct packed {
		logic [7:0] a;
		logic [7:0] b;
	} ramp_state_t;

endpackage

/* File: sink_ramp_if.sv */
`timescale 1ns/10ps
interface sink_ramp_if;
	logic en;
	logic [7:0] target_a;
	logic [7:0] target_b;
	logic [7:0] level_a;
	logic [7:0] level_b;

	modport ctrl (output en, output target_a, output target_b, input level_a, input level_b);
	modport ramp (input en, input target_a, input target_b, output level_a, output level_b);
endinterface

/* File: sink_ramp.sv */
`timescale 1ns/10ps
module sink_ramp (
	// clock and reset
	input wire logic clk,
	input wire logic rstn,
	// control side
	sink_ramp_if.ramp rif
);
	import laser_safety_pkg::*;

	ramp_state_t s_q;
	ramp_state_t s_d;

	// one code per cycle upward; a lowered target is taken at once, so the level never passes it
	function automatic logic [7:0] step(input logic en, input logic [7:0] lvl, input logic [7:0] tgt);
		if (!en) begin
			step = 8'h00;
		end else if (lvl < tgt) begin
			step = 8'(lvl + 8'h01);
		end else begin
			step = tgt;
		end
	endfunction

	always_comb begin
		s_d = s_q;
		s_d.a = step(rif.en, s_q.a, rif.target_a);
		s_d.b = step(rif.en, s_q.b, rif.target_b);
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign rif.level_a = s_q.a;
	assign rif.level_b = s_q.b;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);

	chk_ramp_no_overshoot: assert property (rif.en && $past(rif.en) && s_q.a > $past(s_q.a)
		|-> s_q.a == $past(s_q.a) + 8'h01 && s_q.a <= $past(rif.target_a))
		else $error("sink a ramp stepped by more than one or past its target");
endmodule

/* File: laser_safety_fault_timing.sv */
`timescale 1ns/10ps
`include "laser_safety_map.svh"
// Overview of operation
// - transmit-disable rise turns sinks off fast
// - normal disable release restores sinks within 0.8ms
// - sinks reach programmed values within 100ms after power-up
// - any fast-trip forces sinks off within 50us
// - any fast-trip while transmit-disable is low raises fault output within 50us
// - after fault, disable release restores sinks within 50ms
// - fault output clears 100 to 200ms later
// - software disable drops sinks within 10ms
// - software enable raises sinks within 50ms
// - serial access ready within 200ms of init; ready sets with the 100ms fault clear, not while transmit-disable is held
// - software fault status set within 50ms
// - loss-of-signal indication set within 50ms
// - loss-of-signal indication cleared within 50ms
// - rate-select output follows bit within 50ms
// - sinks high-impedance while transmit-disable high
// - nonvolatile write starts only after bus stop
module laser_safety_fault_timing #(
	parameter int INIT_DAC_CYCLES = `INIT_DAC_CYCLES,
	parameter int FAULT_RESET_CYCLES = `FAULT_RESET_CYCLES
) (
	// clock and reset
	input wire logic clk,
	input wire logic rstn,
	// transmit control
	input wire logic tx_disable_in,
	input wire logic sw_tx_disable,
	input wire logic [7:0] sink_a_setting,
	input wire logic [7:0] sink_b_setting,
	// fast-trip comparators
	input wire logic monitor_high_trip_level,
	input wire logic monitor_low_trip_level,
	input wire logic bias_trip_level,
	// receive and rate select
	input wire logic rx_signal_loss_in,
	input wire logic sw_rate_select,
	// serial write tracking
	input wire logic nv_write_request,
	input wire logic bus_stop,
	// laser current sinks
	output logic [7:0] current_sink_a,
	output logic [7:0] current_sink_b,
	output logic sink_oe,
	// status
	output logic tx_fault_out,
	output logic fault_status,
	output logic serial_ready,
	output logic receive_signal_loss_out,
	output logic rate_select_out,
	output logic nv_write_start
);
	import laser_safety_pkg::*;

	localparam logic [23:0] DAC_CNT = 24'(INIT_DAC_CYCLES);
	localparam logic [23:0] FLT_CNT = 24'(FAULT_RESET_CYCLES);

	ctrl_state_t s_q;
	ctrl_state_t s_d;
	logic trip;

	sink_ramp_if rif ();

	sink_ramp u_ramp (
		.clk(clk),
		.rstn(rstn),
		.rif(rif)
	);

	assign trip = monitor_high_trip_level | monitor_low_trip_level | bias_trip_level;

	// ---------------------------------------------------------------
	// ramp control
	// ---------------------------------------------------------------
	// pins and trips gate the ramp directly so the sinks drop one edge after the cause
	assign rif.en = s_q.sink_en & ~tx_disable_in & ~sw_tx_disable & ~trip;
	assign rif.target_a = sink_a_setting;
	assign rif.target_b = sink_b_setting;

	// ---------------------------------------------------------------
	// next state
	// ---------------------------------------------------------------
	always_comb begin
		s_d = s_q;
		s_d.nv_start = 1'b0;
		s_d.oe = ~tx_disable_in;
		s_d.loss = rx_signal_loss_in;
		s_d.rate = sw_rate_select;
		case (s_q.mode)
			ST_INIT: begin
				if (tx_disable_in) begin
					s_d.mode = ST_DISABLED;
					s_d.sink_en = 1'b0;
					s_d.cnt = 24'h000000;
				end else begin
					s_d.cnt = 24'(s_q.cnt + 24'h000001);
					if (s_q.cnt == DAC_CNT) begin
						s_d.sink_en = 1'b1;
					end
					if (s_q.cnt == FLT_CNT) begin
						s_d.fault = 1'b0;
						s_d.ready = 1'b1;
						s_d.mode = ST_RUN;
					end
					// a trip that persists after the sinks come back means the recovery failed
					if (s_q.sink_en && trip) begin
						s_d.mode = ST_FAULT;
						s_d.fault = 1'b1;
						s_d.sink_en = 1'b0;
					end
				end
			end
			ST_RUN: begin
				if (tx_disable_in) begin
					s_d.mode = ST_DISABLED;
					s_d.sink_en = 1'b0;
				end else if (trip) begin
					s_d.mode = ST_FAULT;
					s_d.fault = 1'b1;
					s_d.sink_en = 1'b0;
				end
			end
			ST_DISABLED: begin
				s_d.sink_en = 1'b0;
				if (!tx_disable_in) begin
					if (s_q.fault) begin
						s_d.mode = ST_INIT;
						s_d.cnt = 24'h000000;
					end else begin
						s_d.mode = ST_RUN;
						s_d.sink_en = 1'b1;
					end
				end
			end
			ST_FAULT: begin
				s_d.sink_en = 1'b0;
				s_d.fault = 1'b1;
				if (tx_disable_in) begin
					s_d.mode = ST_DISABLED;
				end
			end
			default: begin
				s_d.mode = ST_INIT;
				s_d.cnt = 24'h000000;
			end
		endcase
		// the stop that ends a transaction also covers a byte taken in the same cycle
		if (nv_write_request) begin
			s_d.nv_pend = 1'b1;
		end
		if (bus_stop && (s_q.nv_pend || nv_write_request)) begin
			s_d.nv_start = 1'b1;
			s_d.nv_pend = 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			s_q <= '0;
			s_q.mode <= ST_INIT;
			s_q.fault <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end

	// ---------------------------------------------------------------
	// outputs
	// ---------------------------------------------------------------
	assign current_sink_a = rif.level_a;
	assign current_sink_b = rif.level_b;
	assign sink_oe = s_q.oe;
	assign tx_fault_out = s_q.fault;
	assign fault_status = s_q.fault;
	assign serial_ready = s_q.ready;
	assign receive_signal_loss_out = s_q.loss;
	assign rate_select_out = s_q.rate;
	assign nv_write_start = s_q.nv_start;

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);

	chk_disable_sinks_off: assert property ($rose(tx_disable_in)
		|=> current_sink_a == 8'h00 && current_sink_b == 8'h00)
		else $error("sinks not off one cycle after transmit disable");
	chk_normal_recovery: assert property ($fell(tx_disable_in) && s_q.mode == ST_DISABLED && !s_q.fault
		|=> s_q.mode == ST_RUN && s_q.sink_en)
		else $error("normal disable release did not re-enable sinks");
	chk_trip_sinks_off: assert property (trip && s_q.mode == ST_RUN && !tx_disable_in
		|=> current_sink_a == 8'h00 && current_sink_b == 8'h00 && s_q.mode == ST_FAULT)
		else $error("trip did not force sinks off");
	chk_trip_fault_out: assert property (trip && s_q.mode == ST_RUN && !tx_disable_in
		|=> tx_fault_out && fault_status)
		else $error("trip did not raise fault output");
	chk_fault_clear_time: assert property ($fell(tx_fault_out)
		|-> $past(s_q.cnt) == FLT_CNT && serial_ready)
		else $error("fault output cleared at wrong time");
	chk_soft_disable: assert property (sw_tx_disable
		|=> current_sink_a == 8'h00 && current_sink_b == 8'h00)
		else $error("software disable left sinks on");
	chk_loss_follow: assert property (rx_signal_loss_in != receive_signal_loss_out
		|=> receive_signal_loss_out == $past(rx_signal_loss_in))
		else $error("loss-of-signal output lagged");
	chk_rate_follow: assert property ($changed(sw_rate_select) |=> rate_select_out == $past(sw_rate_select))
		else $error("rate-select output lagged");
	chk_disable_hiz: assert property (tx_disable_in |=> !sink_oe)
		else $error("sinks driven while transmit disable high");
	chk_nv_after_stop: assert property (nv_write_start |-> $past(bus_stop))
		else $error("nonvolatile write started without stop");
	chk_fault_latched: assert property (s_q.mode == ST_FAULT && !tx_disable_in
		|=> tx_fault_out && s_q.mode == ST_FAULT)
		else $error("latched fault released without disable toggle");
	chk_init_dac_on: assert property (s_q.mode == ST_INIT && s_q.cnt == DAC_CNT && !tx_disable_in
		|=> s_q.sink_en)
		else $error("sinks not enabled at init point");
	chk_soft_enable: assert property ($fell(sw_tx_disable) && s_q.sink_en && !tx_disable_in && !trip
		&& sink_a_setting != 8'h00 |=> current_sink_a == 8'h01)
		else $error("software enable did not start ramp");

	cov_power_up_run: cover property (s_q.mode == ST_INIT ##1 s_q.mode == ST_RUN);
	cov_trip_fault: cover property (s_q.mode == ST_RUN ##1 s_q.mode == ST_FAULT);
	cov_fault_recover: cover property (s_q.mode == ST_DISABLED && s_q.fault ##1 s_q.mode == ST_INIT);
	cov_nv_write: cover property (nv_write_start);
endmodule

/* File: laser_model.sv */
`timescale 1ns/10ps
// ---------------------------------------------------------------
// laser and monitor diode seen through the fast-trip comparators
// ---------------------------------------------------------------
module laser_model #(
	parameter logic [7:0] HI_LIM = 8'hF0
) (
	// sink codes from the controller
	input wire logic [7:0] level_a,
	input wire logic [7:0] level_b,
	// bench control: aged laser with weak monitor current
	input wire logic degraded,
	// comparator results
	output logic hi_trip,
	output logic lo_trip,
	output logic bias_trip
);
	// overdrive shows up only once the ramp has passed the limit
	assign hi_trip = level_a > HI_LIM;
	assign bias_trip = level_b > HI_LIM;
	assign lo_trip = degraded;
endmodule

/* File: tb_top.sv */
`timescale 1ns/10ps
module tb_top;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic tx_dis = 1'b0, sw_dis = 1'b0, rx_loss = 1'b0, rate = 1'b0;
	logic nv_req = 1'b0, nv_stop = 1'b0, degraded = 1'b0;
	logic [7:0] set_a = 8'h40, set_b = 8'h30;
	logic hi_t, lo_t, bias_t, oe, fault, fstat, ready, loss_o, rate_o, nv_go;
	logic [7:0] sink_a, sink_b;
	int failures = 0;
	int cmp_count = 0;
	int n;
	int e;
	int exp_q[$];
	always #5 clk = ~clk;
	laser_safety_fault_timing #(.INIT_DAC_CYCLES(4), .FAULT_RESET_CYCLES(8)) uut (
		.clk(clk), .rstn(rstn), .tx_disable_in(tx_dis), .sw_tx_disable(sw_dis),
		.sink_a_setting(set_a), .sink_b_setting(set_b), .monitor_high_trip_level(hi_t),
		.monitor_low_trip_level(lo_t), .bias_trip_level(bias_t), .rx_signal_loss_in(rx_loss),
		.sw_rate_select(rate), .nv_write_request(nv_req), .bus_stop(nv_stop),
		.current_sink_a(sink_a), .current_sink_b(sink_b), .sink_oe(oe), .tx_fault_out(fault),
		.fault_status(fstat), .serial_ready(ready), .receive_signal_loss_out(loss_o),
		.rate_select_out(rate_o), .nv_write_start(nv_go));
	laser_model far (.level_a(sink_a), .level_b(sink_b), .degraded(degraded),
		.hi_trip(hi_t), .lo_trip(lo_t), .bias_trip(bias_t));
	// ---------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------
	task automatic end_sim();
		if (failures == 0 && cmp_count > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	task automatic chk(string nm, logic [7:0] seen, logic [7:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			failures++;
			$display("Error %s expected %0h seen %0h", nm, exp, seen);
		end
	endtask
	task automatic cyc(int k);
		repeat (k) @(negedge clk);
	endtask
	// ramp must climb at most one code per cycle and never pass the setting
	task automatic ramp();
		int pa;
		int pb;
		n = 0;
		pa = sink_a;
		pb = sink_b;
		while ((sink_a !== set_a || sink_b !== set_b) && n < 300) begin
			chk("sink_a_cap", sink_a <= set_a, 8'h01);
			chk("sink_b_cap", sink_b <= set_b, 8'h01);
			chk("sink_a_step", sink_a <= pa || sink_a == pa + 1, 8'h01);
			chk("sink_b_step", sink_b <= pb || sink_b == pb + 1, 8'h01);
			pa = sink_a;
			pb = sink_b;
			cyc(1);
			n++;
		end
		if (n == 300) begin
			failures++;
			end_sim();
		end
	endtask
	// fault clears no sooner than the reset count and soon after it
	task automatic fault_wait(int start);
		n = start;
		while (fault !== 1'b0 && n < 50) begin
			cyc(1);
			n++;
		end
		chk("fault_min", n >= 8, 8'h01);
		chk("fault_max", n <= 10, 8'h01);
		chk("fault_status", fstat, 8'h00);
		chk("serial_ready", ready, 8'h01);
		if (n == 50) begin
			end_sim();
		end
		ramp();
	endtask
	// ---------------------------------------------------------------
	// main sequence
	// ---------------------------------------------------------------
	initial begin
		void'($urandom(62382));
		cyc(5);
		rstn = 1'b1;
		cyc(1);
		chk("reset_fault", fault, 8'h01);
		chk("reset_ready", ready, 8'h00);
		chk("reset_sink", sink_a, 8'h00);
		fault_wait(1);
		// hardware disable and normal release
		set_a = 8'h10 + 8'($urandom % 208);
		set_b = 8'h10 + 8'($urandom % 208);
		tx_dis = 1'b1;
		cyc(1);
		chk("dis_sink_a", sink_a, 8'h00);
		chk("dis_sink_b", sink_b, 8'h00);
		chk("dis_oe", oe, 8'h00);
		cyc(3);
		tx_dis = 1'b0;
		cyc(1);
		chk("rel_oe", oe, 8'h01);
		chk("rel_fault", fault, 8'h00);
		ramp();
		// software disable
		sw_dis = 1'b1;
		cyc(1);
		chk("sw_sink_a", sink_a, 8'h00);
		sw_dis = 1'b0;
		ramp();
		// the three fast-trip causes, each latched then recovered
		for (int k = 0; k < 3; k++) begin
			if (k == 0) set_a = 8'hF8;
			if (k == 1) set_b = 8'hF8;
			if (k == 2) degraded = 1'b1;
			n = 0;
			while ((hi_t | lo_t | bias_t) !== 1'b1 && n < 400) begin
				cyc(1);
				n++;
			end
			if (n == 400) begin
				failures++;
				end_sim();
			end
			cyc(1);
			chk("trip_sink_a", sink_a, 8'h00);
			chk("trip_sink_b", sink_b, 8'h00);
			chk("trip_fault", fault, 8'h01);
			chk("trip_status", fstat, 8'h01);
			set_a = 8'h40;
			set_b = 8'h30;
			degraded = 1'b0;
			cyc(4);
			chk("latch_fault", fault, 8'h01);
			chk("latch_sink", sink_a, 8'h00);
			tx_dis = 1'b1;
			cyc(2);
			tx_dis = 1'b0;
			fault_wait(0);
		end
		// status outputs follow their inputs
		repeat (20) begin
			rx_loss = 1'($urandom);
			rate = 1'($urandom);
			exp_q.push_back(2 * rx_loss + rate);
			cyc(1);
			e = exp_q.pop_front();
			chk("loss", loss_o, 8'(e / 2));
			chk("rate", rate_o, 8'(e % 2));
		end
		// power-up with transmit disable held, then released
		rstn = 1'b0;
		tx_dis = 1'b1;
		cyc(2);
		rstn = 1'b1;
		cyc(2);
		chk("rst2_fault", fault, 8'h01);
		chk("rst2_ready", ready, 8'h00);
		chk("rst2_oe", oe, 8'h00);
		chk("rst2_sink", sink_a, 8'h00);
		tx_dis = 1'b0;
		fault_wait(0);
		// nonvolatile write waits for the stop condition
		nv_req = 1'b1;
		cyc(1);
		nv_req = 1'b0;
		cyc(2);
		chk("nv_early", nv_go, 8'h00);
		nv_stop = 1'b1;
		cyc(1);
		chk("nv_start", nv_go, 8'h01);
		nv_stop = 1'b0;
		cyc(1);
		chk("nv_pulse", nv_go, 8'h00);
		nv_stop = 1'b1;
		cyc(1);
		nv_stop = 1'b0;
		chk("nv_idle_stop", nv_go, 8'h00);
		cyc(2);
		// a byte taken in the cycle of the stop belongs to that write
		nv_req = 1'b1;
		nv_stop = 1'b1;
		cyc(1);
		chk("nv_same_cycle", nv_go, 8'h01);
		nv_req = 1'b0;
		nv_stop = 1'b0;
		cyc(1);
		end_sim();
	end
endmodule
